// *** hdl/pmt_consts.svh ***
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
// register byte offsets on the AXI4-Lite bus
`define PMT_OFF_CTRL      8'h00
`define PMT_OFF_ENABLE    8'h04
`define PMT_OFF_RELOAD    8'h08
`define PMT_OFF_CAUSE     8'h0C
`define PMT_OFF_THR_LOW   8'h10
`define PMT_OFF_THR_HIGH  8'h14
`define PMT_OFF_EVENT     8'h18
`define PMT_OFF_STATUS    8'h1C
`define PMT_OFF_PORT      8'h20
// control register fields
`define PMT_CTRL_GATE     0
`define PMT_CTRL_THROTTLE 2
`define PMT_CTRL_FREEZE   3
// cause register fields
`define PMT_CAUSE_PORT    7
`define PMT_CAUSE_EXT     6
`define PMT_CAUSE_IDLE    5
// reset values
`define PMT_RST_CTRL      8'h08
`define PMT_RST_ENABLE    8'h00
`define PMT_RST_RELOAD    8'h00
`define PMT_RST_PERIOD    8'h00
// timing: idle tick in seconds, throttle tick in ns, clock period in ns
`define PMT_CLK_NS        10
`define PMT_THR_TICK_NS   32000
`define PMT_MIN_TICK_S    60
`define PMT_THR_CYCLES    (`PMT_THR_TICK_NS / `PMT_CLK_NS)
`define PMT_MIN_CYCLES    (`PMT_MIN_TICK_S * 64'd1000000000 / `PMT_CLK_NS)
`endif

// *** hdl/pmt_pkg.sv ***
package pmt_pkg;
  // throttle phase machine, gray coded from IDLE through HIGH; HIGH back to WAIT flips both bits
  typedef enum logic [1:0] {
    PMT_IDLE  = 2'b00,
    PMT_WAIT  = 2'b01,
    PMT_LOW   = 2'b11,
    PMT_HIGH  = 2'b10
  } pmt_state_t;

  // one register write as it reaches the register file
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pmt_wr_t;
endpackage : pmt_pkg

// *** hdl/pmt_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// divider giving a one-cycle enable every DIV clocks
module pmt_tick #(
  parameter int unsigned DIV = 3200
) (
  input  wire logic aclk,    // clock
  input  wire logic aresetn, // sync reset, active low
  output logic      tick     // one-cycle pulse
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  // count down and pulse at the wrap
  always_comb begin
    tick_d = (cnt_q == '0);
    cnt_d  = tick_d ? W'(DIV - 1) : cnt_q - W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule : pmt_tick
`default_nettype wire

// *** hdl/pmt_top.sv ***
// Function
// - writing the idle reload while frozen loads the idle counter
// - reading the idle reload returns the last written value
// - idle counter counts down whenever freeze bit is clear
// - idle counter reaching zero raises a management interrupt request
// - an enabled system event before expiry reloads the idle counter
// - hardware sets the cause bit of an enabled interrupting event
// - writing 0 clears a cause bit, writing 1 does nothing
// - hardware set wins over a same-cycle software clear
// - cause bit 7 is port write, bit 6 the external input
// - bit 5 idle expiry, bits 4..0 lines 12, 8, 4, 3, 1
// - cause bits 15..8 are reserved and read zero
// - stop-grant after stop-clock assertion loads throttle timer from low-period register
// - stop-clock deasserted loads throttle timer from high-period register
// - throttle timer advances once per 32 us tick
// - asserted period count waits for the stop-grant cycle
// - idle counter decrements once per 1705032704 clocks, about 17 s, as int' keeps the low 32 bits of MIN_CYCLES
// - freeze bit stops the idle counter
// - throttle enable bit turns on periodic stop-clock
`include "pmt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pmt_top
  import pmt_pkg::*;
#(
  parameter longint unsigned MIN_CYCLES = `PMT_MIN_CYCLES,
  parameter int unsigned     THR_CYCLES = `PMT_THR_CYCLES
) (
  input  wire logic        aclk,            // clock
  input  wire logic        aresetn,         // sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read valid
  input  wire logic        s_axi_rready,    // read ready
  input  wire logic        external_mgmt_input_n, // external request
  input  wire logic [4:0]  irq_lines,       // lines 12,8,4,3,1 as 4..0
  input  wire logic [15:0] system_event,    // system activity pulses
  input  wire logic        stop_grant,      // stop-grant cycle seen
  output logic             mgmt_interrupt_out_n,   // interrupt, low
  output logic             cpu_stop_clock_request_n // stop clock, low
);
  // bus handshake state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, bresp_err_q, bresp_err_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rresp_err_q, rresp_err_d;
  pmt_wr_t     wr;
  // software registers
  logic [7:0]  ctrl_q, ctrl_d, enable_q, enable_d, reload_q, reload_d;
  logic [7:0]  thr_low_q, thr_low_d, thr_high_q, thr_high_d;
  logic [15:0] event_en_q, event_en_d;
  logic [7:0]  cause_q, cause_d;
  logic        port_wr;
  // idle counter and throttle
  logic [7:0]  idle_q, idle_d;
  logic        expired_q, expired_d;
  logic [7:0]  thr_q, thr_d;
  pmt_state_t  st_q, st_d;
  logic        gate_q, gate_d;
  logic        cpu_stop_clock_request_q, cpu_stop_clock_request_d;
  logic        min_tick, thr_tick;
  logic [7:0]  set_vec;
  logic        sys_event;

  // byte-lane merge used by the ctrl, enable, reload and period registers
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input pmt_wr_t w);
    lane0 = w.strb[0] ? w.data[7:0] : old;
  endfunction : lane0

  function automatic logic hit(input pmt_wr_t w, input logic [7:0] off);
    hit = w.en && (w.addr == off);
  endfunction : hit

  // AXI4-Lite slave: address and data taken in either order, then B
  always_comb begin
    aw_have_d   = aw_have_q;
    w_have_d    = w_have_q;
    aw_addr_d   = aw_addr_q;
    w_data_d    = w_data_q;
    w_strb_d    = w_strb_q;
    bvalid_d    = bvalid_q;
    bresp_err_d = bresp_err_q;
    wr          = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_d = 1'b0;
    if (aw_have_q && w_have_q && !bvalid_q) begin
      wr.en       = 1'b1;
      wr.addr     = {aw_addr_q[7:2], 2'b00};
      wr.data     = w_data_q;
      wr.strb     = w_strb_q;
      aw_have_d   = 1'b0;
      w_have_d    = 1'b0;
      bvalid_d    = 1'b1;
      bresp_err_d = (aw_addr_q[7:2] > 6'(`PMT_OFF_PORT >> 2));
    end
  end

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_err_q ? 2'b10 : 2'b00;

  // read path: one cycle from address to data
  always_comb begin
    rvalid_d    = rvalid_q;
    rdata_d     = rdata_q;
    rresp_err_d = rresp_err_q;
    if (s_axi_rvalid && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d    = 1'b1;
      rresp_err_d = 1'b0;
      case ({s_axi_araddr[7:2], 2'b00})
        `PMT_OFF_CTRL:     rdata_d = {24'h0, ctrl_q};
        `PMT_OFF_ENABLE:   rdata_d = {24'h0, enable_q};
        `PMT_OFF_RELOAD:   rdata_d = {24'h0, reload_q};
        `PMT_OFF_CAUSE:    rdata_d = {24'h0, cause_q};
        `PMT_OFF_THR_LOW:  rdata_d = {24'h0, thr_low_q};
        `PMT_OFF_THR_HIGH: rdata_d = {24'h0, thr_high_q};
        `PMT_OFF_EVENT:    rdata_d = {16'h0, event_en_q};
        `PMT_OFF_STATUS:   rdata_d = {14'h0, cpu_stop_clock_request_q, expired_q,
                                      thr_q, idle_q};
        `PMT_OFF_PORT:     rdata_d = 32'h0;
        default: begin
          rdata_d     = 32'h0;
          rresp_err_d = 1'b1;
        end
      endcase
    end
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_err_q ? 2'b10 : 2'b00;

  // tick dividers: one per 1705032704 clocks (MIN_CYCLES cut to 32 bits by int') and one per 32 us
  pmt_tick #(.DIV(int'(MIN_CYCLES))) u_min_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (min_tick)
  );
  pmt_tick #(.DIV(THR_CYCLES)) u_thr_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (thr_tick)
  );

  assign port_wr   = hit(wr, `PMT_OFF_PORT);
  assign sys_event = |(system_event & event_en_q);

  // raw causes gated by their enables
  always_comb begin
    set_vec = '0;
    set_vec[`PMT_CAUSE_PORT] = port_wr;
    set_vec[`PMT_CAUSE_EXT]  = !external_mgmt_input_n;
    set_vec[`PMT_CAUSE_IDLE] = expired_d && !expired_q;
    set_vec[4:0]             = irq_lines;
    set_vec = set_vec & enable_q;
  end

  // register file; cause clears on written zeros, but sets dominate
  always_comb begin
    ctrl_d     = ctrl_q;
    enable_d   = enable_q;
    reload_d   = reload_q;
    thr_low_d  = thr_low_q;
    thr_high_d = thr_high_q;
    event_en_d = event_en_q;
    cause_d    = cause_q;
    gate_d     = gate_q;
    if (hit(wr, `PMT_OFF_CTRL)) begin
      ctrl_d = lane0(ctrl_q, wr);
      if (wr.strb[0])
        gate_d = wr.data[`PMT_CTRL_GATE];
    end
    if (hit(wr, `PMT_OFF_ENABLE))
      enable_d = lane0(enable_q, wr);
    if (hit(wr, `PMT_OFF_RELOAD))
      reload_d = lane0(reload_q, wr);
    if (hit(wr, `PMT_OFF_THR_LOW))
      thr_low_d = lane0(thr_low_q, wr);
    if (hit(wr, `PMT_OFF_THR_HIGH))
      thr_high_d = lane0(thr_high_q, wr);
    if (hit(wr, `PMT_OFF_EVENT)) begin
      if (wr.strb[0]) event_en_d[7:0]  = wr.data[7:0];
      if (wr.strb[1]) event_en_d[15:8] = wr.data[15:8];
    end
    if (hit(wr, `PMT_OFF_CAUSE) && wr.strb[0])
      cause_d = cause_q & wr.data[7:0];
    cause_d = cause_d | set_vec;
  end

  // idle counter: frozen, loaded, reloaded on activity, counted per min_tick
  always_comb begin
    idle_d    = idle_q;
    expired_d = expired_q;
    if (ctrl_q[`PMT_CTRL_FREEZE]) begin
      if (hit(wr, `PMT_OFF_RELOAD) && wr.strb[0]) begin
        idle_d    = wr.data[7:0];
        expired_d = 1'b0;
      end
    end else if (sys_event && !expired_q) begin
      idle_d = reload_q;
    end else if (min_tick && idle_q != 8'h00) begin
      idle_d = idle_q - 8'h01;
    end
    if (!ctrl_q[`PMT_CTRL_FREEZE] && idle_d == 8'h00 && !sys_event)
      expired_d = 1'b1;
    if (sys_event && !ctrl_q[`PMT_CTRL_FREEZE])
      expired_d = 1'b0;
  end

  // throttle phase machine; the low-phase count starts only after stop-grant
  always_comb begin
    st_d     = st_q;
    thr_d    = thr_q;
    cpu_stop_clock_request_d = cpu_stop_clock_request_q;
    case (st_q)
      PMT_IDLE: begin
        if (ctrl_q[`PMT_CTRL_THROTTLE]) begin
          cpu_stop_clock_request_d = 1'b1;
          st_d     = PMT_WAIT;
        end
      end
      PMT_WAIT: begin
        if (stop_grant) begin
          thr_d = thr_low_q;
          st_d  = PMT_LOW;
        end
      end
      PMT_LOW: begin
        if (thr_tick) begin
          if (thr_q == 8'h00) begin
            cpu_stop_clock_request_d = 1'b0;
            thr_d    = thr_high_q;
            st_d     = PMT_HIGH;
          end else begin
            thr_d = thr_q - 8'h01;
          end
        end
      end
      PMT_HIGH: begin
        if (thr_tick) begin
          if (thr_q == 8'h00) begin
            cpu_stop_clock_request_d = 1'b1;
            st_d     = PMT_WAIT;
          end else begin
            thr_d = thr_q - 8'h01;
          end
        end
      end
      default: st_d = PMT_IDLE;
    endcase
    // leaving throttle releases stop-clock at once
    if (!ctrl_q[`PMT_CTRL_THROTTLE]) begin
      st_d     = PMT_IDLE;
      cpu_stop_clock_request_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q   <= 1'b0;
      w_have_q    <= 1'b0;
      aw_addr_q   <= 8'h00;
      w_data_q    <= 32'h0;
      w_strb_q    <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_err_q <= 1'b0;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0;
      rresp_err_q <= 1'b0;
      ctrl_q      <= `PMT_RST_CTRL;
      enable_q    <= `PMT_RST_ENABLE;
      reload_q    <= `PMT_RST_RELOAD;
      thr_low_q   <= `PMT_RST_PERIOD;
      thr_high_q  <= `PMT_RST_PERIOD;
      event_en_q  <= 16'h0;
      cause_q     <= 8'h00;
      gate_q      <= 1'b0;
      idle_q      <= `PMT_RST_RELOAD;
      expired_q   <= 1'b0;
      thr_q       <= 8'h00;
      st_q        <= PMT_IDLE;
      cpu_stop_clock_request_q    <= 1'b0;
    end else begin
      aw_have_q   <= aw_have_d;
      w_have_q    <= w_have_d;
      aw_addr_q   <= aw_addr_d;
      w_data_q    <= w_data_d;
      w_strb_q    <= w_strb_d;
      bvalid_q    <= bvalid_d;
      bresp_err_q <= bresp_err_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_err_q <= rresp_err_d;
      ctrl_q      <= ctrl_d;
      enable_q    <= enable_d;
      reload_q    <= reload_d;
      thr_low_q   <= thr_low_d;
      thr_high_q  <= thr_high_d;
      event_en_q  <= event_en_d;
      cause_q     <= cause_d;
      gate_q      <= gate_d;
      idle_q      <= idle_d;
      expired_q   <= expired_d;
      thr_q       <= thr_d;
      st_q        <= st_d;
      cpu_stop_clock_request_q    <= cpu_stop_clock_request_d;
    end
  end

  // pins registered so they never glitch
  logic irq_pin_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_pin_q <= 1'b0;
    else
      irq_pin_q <= gate_d && (cause_d != 8'h00);
  end
  assign mgmt_interrupt_out_n     = !irq_pin_q;
  assign cpu_stop_clock_request_n = !cpu_stop_clock_request_q;
endmodule : pmt_top
`default_nettype wire

// *** verification/pmt_checker.sv ***
`include "pmt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// port-level watch of the register bus and the stop-clock handshake
module pmt_checker #(
  parameter longint unsigned MIN_CYCLES = 20,
  parameter int unsigned     THR_CYCLES = 4
) (
  input wire logic        aclk,                     // clock
  input wire logic        aresetn,                  // sync reset, low
  input wire logic        s_axi_awvalid,            // aw valid
  input wire logic        s_axi_awready,            // aw ready
  input wire logic        s_axi_wvalid,             // w valid
  input wire logic        s_axi_wready,             // w ready
  input wire logic [1:0]  s_axi_bresp,              // b resp
  input wire logic        s_axi_bvalid,             // b valid
  input wire logic        s_axi_bready,             // b ready
  input wire logic [7:0]  s_axi_araddr,             // ar addr
  input wire logic        s_axi_arvalid,            // ar valid
  input wire logic        s_axi_arready,            // ar ready
  input wire logic [31:0] s_axi_rdata,              // r data
  input wire logic [1:0]  s_axi_rresp,              // r resp
  input wire logic        s_axi_rvalid,             // r valid
  input wire logic        s_axi_rready,             // r ready
  input wire logic        stop_grant,               // grant seen
  input wire logic        cpu_stop_clock_request_n  // stop clock, low
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       grant_q, grant_d, busy;
  logic [7:0] ra_q, ra_d;
  // a write in flight may legally end the request, so it is excluded
  assign busy = s_axi_awvalid | s_axi_wvalid | s_axi_bvalid;
  // grant seen in this request, and the address of the open read
  always_comb begin
    grant_d = grant_q & ~cpu_stop_clock_request_n;
    if (!cpu_stop_clock_request_n && stop_grant) grant_d = 1'b1;
    ra_d = ra_q;
    if (s_axi_arvalid && s_axi_arready) ra_d = s_axi_araddr;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_q <= 1'b0;
      ra_q    <= 8'h00;
    end else begin
      grant_q <= grant_d;
      ra_q    <= ra_d;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence req_waiting;
    !cpu_stop_clock_request_n && !grant_q && !stop_grant && !busy &&
      !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endsequence
  aw_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response is pending");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while read data is pending");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  unmapped_rd_a: assert property (s_axi_rvalid && ra_q > `PMT_OFF_PORT |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cause_rsvd_a: assert property (
    s_axi_rvalid && ra_q == `PMT_OFF_CAUSE |-> s_axi_rdata[15:8] == 8'h00)
    else $error("reserved cause bits set");
  grant_wait_a: assert property (
    req_waiting |=> !cpu_stop_clock_request_n)
    else $error("stop clock released before grant");
endmodule : pmt_checker
bind pmt_top pmt_checker #(.MIN_CYCLES(MIN_CYCLES), .THR_CYCLES(THR_CYCLES))
  u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .stop_grant(stop_grant),
  .cpu_stop_clock_request_n(cpu_stop_clock_request_n));
`default_nettype wire

// *** verification/pmt_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// cpu side: answers a stop-clock request with one stop-grant pulse
module pmt_cpu_model (
  input  wire logic       aclk,                     // clock
  input  wire logic       aresetn,                  // sync reset, low
  input  wire logic       cpu_stop_clock_request_n, // request, low
  input  wire logic [7:0] grant_dly,                // answer delay
  output logic            stop_grant                // grant pulse
);
  logic [7:0] cnt_q, cnt_d;
  logic       done_q, done_d, grant_d;
  // one grant per request, never a second one
  always_comb begin
    cnt_d   = cnt_q;
    done_d  = done_q;
    grant_d = 1'b0;
    if (cpu_stop_clock_request_n) begin
      cnt_d  = 8'h00;
      done_d = 1'b0;
    end else if (!done_q && cnt_q == grant_dly) begin
      grant_d = 1'b1;
      done_d  = 1'b1;
    end else if (!done_q) begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  // registered, so a grant never lands in the request's own cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q      <= 8'h00;
      done_q     <= 1'b0;
      stop_grant <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      done_q     <= done_d;
      stop_grant <= grant_d;
    end
  end
endmodule : pmt_cpu_model
`default_nettype wire

// *** verification/pmt_top_tb_top.sv ***
`include "pmt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pmt_top_tb_top;
  localparam longint unsigned MIN = 20;
  localparam int unsigned     THR = 4;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ext_n, grant;
  logic        irq_n, stp_n;
  logic [7:0]  awaddr, araddr, gdly;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [4:0]  irq;
  logic [15:0] sys_ev;
  int          err_total, tests_run;
  pmt_top #(.MIN_CYCLES(MIN), .THR_CYCLES(THR)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_mgmt_input_n(ext_n), .irq_lines(irq), .system_event(sys_ev),
    .stop_grant(grant), .mgmt_interrupt_out_n(irq_n),
    .cpu_stop_clock_request_n(stp_n));
  pmt_cpu_model cpu (.aclk(aclk), .aresetn(aresetn),
    .cpu_stop_clock_request_n(stp_n), .grant_dly(gdly), .stop_grant(grant));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic fail_out;
    err_total++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask : fail_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("unexpected at %0t: span %0d", $time, n);
    end
  endtask : chk_in
  // ready is sampled mid-cycle, where it is settled, and acted on at the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic       ah, wh, bh;
    logic [1:0] r;
    int         n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bh = 1'b0;
    for (n = 0; n < 100 && !bh; n++) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) fail_out();
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, rh;
    int   n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rh = 1'b0;
    for (n = 0; n < 100 && !rh; n++) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) fail_out();
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rchk
  // counts cycles while a pin keeps a level: sel 1 irq pin, 0 stop clock
  task automatic hold(input logic sel, input logic lvl, output int n);
    n = 0;
    @(negedge aclk);
    while ((sel ? irq_n : stp_n) === lvl && n < 3000) begin
      n++;
      @(negedge aclk);
    end
    if (n == 3000) fail_out();
  endtask : hold
  task automatic fire(input int i);
    @(posedge aclk);
    if (i < 5) irq <= 5'h01 << i;
    else if (i == 6) ext_n <= 1'b0;
    if (i == 7) wr(`PMT_OFF_PORT, 32'h0);
    else begin
      @(posedge aclk);
      irq   <= 5'h00;
      ext_n <= 1'b1;
    end
  endtask : fire
  task automatic t_regs;
    rchk(`PMT_OFF_CTRL, 32'h8);
    rchk(`PMT_OFF_RELOAD, 32'h0);
    rchk(`PMT_OFF_CAUSE, 32'h0);
    wr(`PMT_OFF_RELOAD, 32'h5A); // freeze is set out of reset
    rchk(`PMT_OFF_RELOAD, 32'h5A);
    wr(8'h24, 32'h1, 2'h2);
    rchk(8'h24, 32'h0, 2'h2);
    $display("test regs done");
  endtask : t_regs
  task automatic t_cause;
    int i;
    wr(`PMT_OFF_ENABLE, 32'hFF);
    wr(`PMT_OFF_CTRL, 32'h9);
    for (i = 0; i < 8; i++) begin
      if (i != 5) begin
        fire(i);
        rchk(`PMT_OFF_CAUSE, 32'h1 << i);
        chk({31'h0, irq_n}, 32'h0);
        wr(`PMT_OFF_CAUSE, 32'hFFFF);
        rchk(`PMT_OFF_CAUSE, 32'h1 << i);
        wr(`PMT_OFF_CAUSE, 32'h0);
        rchk(`PMT_OFF_CAUSE, 32'h0);
        chk({31'h0, irq_n}, 32'h1);
      end
    end
    @(posedge aclk);
    irq <= 5'h01;
    wr(`PMT_OFF_CAUSE, 32'h0);
    rchk(`PMT_OFF_CAUSE, 32'h1);
    irq <= 5'h00;
    wr(`PMT_OFF_CTRL, 32'h8);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq_n}, 32'h1);
    wr(`PMT_OFF_CAUSE, 32'h0);
    wr(`PMT_OFF_ENABLE, 32'h0);
    fire(0);
    rchk(`PMT_OFF_CAUSE, 32'h0);
    $display("test cause done");
  endtask : t_cause
  task automatic t_idle;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(`PMT_OFF_ENABLE, 32'h20);
    wr(`PMT_OFF_EVENT, 32'h1);
    wr(`PMT_OFF_CTRL, 32'h9);
    wr(`PMT_OFF_RELOAD, 32'h4);
    repeat (3 * MIN) @(negedge aclk);
    rd(`PMT_OFF_STATUS, d, r);
    chk(d & 32'hFF, 32'h4);
    wr(`PMT_OFF_CTRL, 32'h1);
    repeat (2 * MIN + 2) @(negedge aclk);
    rd(`PMT_OFF_STATUS, d, r);
    chk({31'h0, d[7:0] < 8'h3}, 32'h1);
    rchk(`PMT_OFF_RELOAD, 32'h4);
    @(posedge aclk);
    sys_ev <= 16'h1;
    @(posedge aclk);
    sys_ev <= 16'h0;
    // without the reload the pin would fall within two minute ticks
    hold(1'b1, 1'b1, n);
    chk_in(n, 3 * MIN - 4, 4 * MIN + 8);
    rchk(`PMT_OFF_CAUSE, 32'h20);
    wr(`PMT_OFF_CTRL, 32'h8);
    wr(`PMT_OFF_CAUSE, 32'h0);
    $display("test idle done");
  endtask : t_idle
  task automatic t_thr(input logic [7:0] dly);
    int n;
    @(posedge aclk);
    gdly <= dly;
    wr(`PMT_OFF_THR_LOW, 32'h2);
    wr(`PMT_OFF_THR_HIGH, 32'h1);
    wr(`PMT_OFF_CTRL, 32'hC);
    hold(1'b0, 1'b1, n);
    chk_in(n, 0, 3);
    hold(1'b0, 1'b0, n);
    chk_in(n, dly + 2 * THR, dly + 3 * THR + 8);
    hold(1'b0, 1'b1, n);
    chk_in(n, THR, 2 * THR + 4);
    wr(`PMT_OFF_CTRL, 32'h8);
    repeat (2) @(negedge aclk);
    chk({31'h0, stp_n}, 32'h1);
    $display("test throttle done");
  endtask : t_thr
  // inputs settle at time zero, reset is held for six cycles
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, irq, sys_ev} = 69'h0;
    ext_n = 1'b1;
    gdly = 8'h01;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cause();
    t_idle();
    t_thr(8'h01);
    t_thr(8'h0A);
    test_done();
  end
endmodule : pmt_top_tb_top
`default_nettype wire
